// *** include/dcai_pkg.sv ***
// dcai_pkg: shared constants and types of the ddr3 command/address device.
// assumes every user refers to items as dcai_pkg::name, nothing imported.
// How it works
// - chip select high masks every command
// - command and address inputs sampled on rising true clock
// - clock gate low enters power-down or self refresh
// - clock gate exits self refresh without clock
// - power-down and self refresh ignore commands; termination input ignored only in self refresh
// - termination only when registered high and enabled
// - command from row, column, write strobes
// - masked write beats are not stored
// - bank select picks bank or mode register
// - address carries row, column or op code
// - address bit ten requests auto precharge
// - precharge bit ten closes one or all
// - address bit twelve low chops the burst
// - active low asynchronous device reset
// - lane strobes edge aligned on reads
// - strobes used only as differential pairs
// - two beats per clock, eight beat burst
// - outputs aligned to input clock edges
// - on-the-fly chop only when mode allows
package dcai_pkg;
	localparam int NBANK        = 8;
	localparam int BA_W         = 3;
	localparam int ADDR_W       = 16;
	localparam int COL_W        = 10;
	localparam int LANE_W       = 8;
	localparam int ROW_KEEP_DEF = 2;
	localparam int RD_LAT_DEF   = 5;
	localparam int WR_LAT_DEF   = 5;
	localparam int LAT_W        = 4;
	localparam int MR_NUM       = 4;
	localparam int AP_BIT       = 10;
	localparam int BC_BIT       = 12;
	// command codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_ZQ  = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;
	// burst length field of mode register 0, bits 1:0
	localparam int         BL_LSB  = 0;
	localparam logic [1:0] BL_FIX8 = 2'h0;
	localparam logic [1:0] BL_OTF  = 2'h1;
	localparam logic [1:0] BL_FIX4 = 2'h2;
	// termination value fields: mode register 1 and 2
	localparam int RTT_NOM_B0 = 2;
	localparam int RTT_NOM_B1 = 6;
	localparam int RTT_NOM_B2 = 9;
	localparam int RTT_WR_B0  = 9;
	localparam int RTT_WR_B1  = 10;
	localparam logic [ADDR_W-1:0] MR_RST = 16'h0000;
	// last beat pair index of a burst
	localparam logic [1:0] PAIR_LAST8 = 2'h3;
	localparam logic [1:0] PAIR_LAST4 = 2'h1;
	// status bits carried to the core clock
	localparam int ST_SR   = 0;
	localparam int ST_PD   = 1;
	localparam int ST_TERM = 2;
	localparam int ST_OPEN = 3;
	localparam int ST_BUSY = 4;
	localparam int ST_W    = 5;
	typedef enum logic [1:0] {pwr_run, pwr_pd_pre, pwr_pd_act} dcai_pwr_e;
endpackage

// *** rtl/dcai_mem.sv ***
// dcai_mem: array of beat pairs, byte write enables, registered read.
// assumes one clock; read data valid the edge after the address.
`timescale 1ns/1ps
module dcai_mem #(
	parameter int DW = 32,
	parameter int AW = 14
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [DW/8-1:0] be,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output      logic [DW-1:0] rdata_q
);
	logic [DW-1:0] mem [2**AW];

	for (genvar i = 0; i < DW / 8; i++) begin : g_byte
		always_ff @(posedge clk) begin
			if (we && be[i]) begin
				mem[addr][8*i +: 8] <= wdata[8*i +: 8];
			end
		end
	end

	always_ff @(posedge clk) begin
		rdata_q <= mem[addr];
	end
endmodule

// *** rtl/dcai_device.sv ***
// dcai_device: device side of a x16 ddr3 command, address and data port.
// assumes ck is the controller's clock, commands on its rising edge;
// core_clk only receives status through three-flop synchronisers.
`timescale 1ns/1ps
module dcai_device #(
	parameter int ROW_KEEP = dcai_pkg::ROW_KEEP_DEF,
	parameter int RD_LAT   = dcai_pkg::RD_LAT_DEF,
	parameter int WR_LAT   = dcai_pkg::WR_LAT_DEF
) (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        ck,
	input  wire logic        mem_reset_n,
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [2:0]  bank_select,
	input  wire logic [15:0] addr,
	input  wire logic        termination_ctrl,
	input  wire logic        write_mask_lower,
	input  wire logic        write_mask_upper,
	input  wire logic [7:0]  data_low_lane_i,
	output      logic [7:0]  data_low_lane_o,
	output      logic        data_low_lane_oe_n,
	input  wire logic [7:0]  data_high_lane_i,
	output      logic [7:0]  data_high_lane_o,
	output      logic        data_high_lane_oe_n,
	input  wire logic        strobe_low_lane_i,
	input  wire logic        strobe_low_lane_n_i,
	output      logic        strobe_low_lane_o,
	output      logic        strobe_low_lane_n_o,
	output      logic        strobe_low_lane_oe_n,
	input  wire logic        strobe_high_lane_i,
	input  wire logic        strobe_high_lane_n_i,
	output      logic        strobe_high_lane_o,
	output      logic        strobe_high_lane_n_o,
	output      logic        strobe_high_lane_oe_n,
	output      logic        term_enable,
	output      logic        core_self_refresh,
	output      logic        core_power_down,
	output      logic        core_term_active,
	output      logic        core_bank_open,
	output      logic        core_burst_busy
);
	localparam int BA_W   = dcai_pkg::BA_W;
	localparam int NBANK  = dcai_pkg::NBANK;
	localparam int LAT_W  = dcai_pkg::LAT_W;
	localparam int MEM_AW = BA_W + ROW_KEEP + dcai_pkg::COL_W - 1;

	logic                  lrst_a_q;
	logic                  link_rst_n_q;
	logic                  crst_a_q;
	logic                  core_rst_n_q;
	logic                  cke_q;
	logic                  sr_q;
	dcai_pkg::dcai_pwr_e   pwr_q;
	logic [3:0]            cmd_w;
	logic                  cmd_en;
	logic                  act_w;
	logic                  rd_w;
	logic                  wr_w;
	logic                  pre_w;
	logic                  mrs_w;
	logic                  sre_w;
	logic                  start_w;
	logic                  chop_w;
	logic                  rtt_on;
	logic                  term_q;
	logic [NBANK-1:0]      open_q;
	logic [ROW_KEEP-1:0]   row_q [NBANK];
	logic [15:0]           mr_q [dcai_pkg::MR_NUM];
	logic                  busy_q;
	logic                  run_q;
	logic [LAT_W-1:0]      lat_q;
	logic [1:0]            cnt_q;
	logic                  is_wr_q;
	logic                  ap_q;
	logic                  chop_q;
	logic [BA_W-1:0]       bank_q;
	logic [9:0]            col_q;
	logic [1:0]            last_w;
	logic [1:0]            pair_w;
	logic                  ap_fire;
	logic [MEM_AW-1:0]     mem_addr;
	logic                  mem_we;
	logic [3:0]            mem_be;
	logic [31:0]           mem_wdata;
	logic [31:0]           mem_rdata_q;
	logic [7:0]            wa_lo_q;
	logic [7:0]            wa_hi_q;
	logic                  wa_ml_q;
	logic                  wa_mu_q;
	logic                  dqs_ok_lo;
	logic                  dqs_ok_hi;
	logic                  rd_v_q;
	logic                  drive_q;
	logic [15:0]           b_hold_q;
	logic [15:0]           dq_p_q;
	logic [15:0]           dq_n_q;
	logic                  dqs_p_q;
	logic                  dqs_n_q;
	logic [15:0]           dq_out;
	logic                  dqs_out;
	logic [dcai_pkg::ST_W-1:0] st_w;
	logic [dcai_pkg::ST_W-1:0] st_q;

	always_ff @(posedge ck or negedge mem_reset_n) begin
		if (!mem_reset_n) begin
			lrst_a_q     <= 1'b0;
			link_rst_n_q <= 1'b0;
		end else begin
			lrst_a_q     <= 1'b1;
			link_rst_n_q <= lrst_a_q;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			crst_a_q     <= 1'b0;
			core_rst_n_q <= 1'b0;
		end else begin
			crst_a_q     <= 1'b1;
			core_rst_n_q <= crst_a_q;
		end
	end

	assign cmd_w  = {cs_n, ras_n, cas_n, we_n};
	assign cmd_en = cke && cke_q && pwr_q == dcai_pkg::pwr_run && !sr_q;
	assign act_w = cmd_en && cmd_w == dcai_pkg::CMD_ACT;
	assign rd_w  = cmd_en && cmd_w == dcai_pkg::CMD_RD;
	assign wr_w  = cmd_en && cmd_w == dcai_pkg::CMD_WR;
	assign pre_w = cmd_en && cmd_w == dcai_pkg::CMD_PRE;
	assign mrs_w = cmd_en && cmd_w == dcai_pkg::CMD_MRS;
	assign sre_w = cke_q && !cke && !sr_q && pwr_q == dcai_pkg::pwr_run
		&& cmd_w == dcai_pkg::CMD_REF;

	always_ff @(posedge ck or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			cke_q <= 1'b0;
		end else begin
			cke_q <= cke;
		end
	end

	always_ff @(posedge ck or negedge link_rst_n_q or posedge cke) begin
		if (!link_rst_n_q) begin
			sr_q <= 1'b0;
		end else if (cke) begin
			sr_q <= 1'b0;
		end else if (sre_w) begin
			sr_q <= 1'b1;
		end
	end

	always_ff @(posedge ck or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			pwr_q <= dcai_pkg::pwr_run;
		end else begin
			case (pwr_q)
				dcai_pkg::pwr_run: begin
					if (cke_q && !cke && !sre_w && !sr_q) begin
						pwr_q <= (|open_q) ? dcai_pkg::pwr_pd_act
							: dcai_pkg::pwr_pd_pre;
					end
				end
				dcai_pkg::pwr_pd_pre, dcai_pkg::pwr_pd_act: begin
					if (cke) begin
						pwr_q <= dcai_pkg::pwr_run;
					end
				end
				default: pwr_q <= dcai_pkg::pwr_run;
			endcase
		end
	end

	always_ff @(posedge ck or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			for (int i = 0; i < dcai_pkg::MR_NUM; i++) begin
				mr_q[i] <= dcai_pkg::MR_RST;
			end
		end else if (mrs_w) begin
			mr_q[bank_select[1:0]] <= addr;
		end
	end

	assign rtt_on = mr_q[1][dcai_pkg::RTT_NOM_B0]
		|| mr_q[1][dcai_pkg::RTT_NOM_B1] || mr_q[1][dcai_pkg::RTT_NOM_B2]
		|| mr_q[2][dcai_pkg::RTT_WR_B0] || mr_q[2][dcai_pkg::RTT_WR_B1];

	always_ff @(posedge ck or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			term_q <= 1'b0;
		end else begin
			term_q <= termination_ctrl && rtt_on && !sr_q && !sre_w;
		end
	end
	assign term_enable = term_q;

	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		always_ff @(posedge ck or negedge link_rst_n_q) begin
			if (!link_rst_n_q) begin
				open_q[b] <= 1'b0;
				row_q[b]  <= '0;
			end else if (act_w && bank_select == BA_W'(b)) begin
				open_q[b] <= 1'b1;
				row_q[b]  <= addr[ROW_KEEP-1:0];
			end else if (pre_w && (addr[dcai_pkg::AP_BIT]
				|| bank_select == BA_W'(b))) begin
				open_q[b] <= 1'b0;
			end else if (ap_fire && bank_q == BA_W'(b)) begin
				open_q[b] <= 1'b0;
			end
		end
	end

	assign chop_w = mr_q[0][1:0] == dcai_pkg::BL_FIX4
		|| (mr_q[0][1:0] == dcai_pkg::BL_OTF && !addr[dcai_pkg::BC_BIT]);
	assign start_w = (rd_w || wr_w) && !busy_q;
	assign last_w  = chop_q ? dcai_pkg::PAIR_LAST4 : dcai_pkg::PAIR_LAST8;
	assign ap_fire = run_q && cnt_q == last_w && ap_q;

	always_ff @(posedge ck or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			busy_q  <= 1'b0;
			run_q   <= 1'b0;
			lat_q   <= '0;
			cnt_q   <= '0;
			is_wr_q <= 1'b0;
			ap_q    <= 1'b0;
			chop_q  <= 1'b0;
			bank_q  <= '0;
			col_q   <= '0;
		end else if (start_w) begin
			busy_q  <= 1'b1;
			lat_q   <= wr_w ? LAT_W'(WR_LAT) : LAT_W'(RD_LAT);
			cnt_q   <= '0;
			is_wr_q <= wr_w;
			ap_q    <= addr[dcai_pkg::AP_BIT];
			chop_q  <= chop_w;
			bank_q  <= bank_select;
			col_q   <= addr[9:0];
		end else if (busy_q && !run_q) begin
			if (lat_q <= LAT_W'(1)) begin
				run_q <= 1'b1;
			end else begin
				lat_q <= lat_q - LAT_W'(1);
			end
		end else if (run_q) begin
			cnt_q <= cnt_q + 2'h1;
			if (cnt_q == last_w) begin
				run_q  <= 1'b0;
				busy_q <= 1'b0;
			end
		end
	end

	// sequential order within the chopped or full burst
	assign pair_w = chop_q ? {col_q[2], col_q[1] ^ cnt_q[0]}
		: 2'(col_q[2:1] + cnt_q);
	assign mem_addr = {bank_q, row_q[bank_q], col_q[9:3], pair_w};

	assign dqs_ok_lo = strobe_low_lane_i ^ strobe_low_lane_n_i;
	assign dqs_ok_hi = strobe_high_lane_i ^ strobe_high_lane_n_i;

	always_ff @(negedge ck or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			wa_lo_q <= '0;
			wa_hi_q <= '0;
			wa_ml_q <= 1'b1;
			wa_mu_q <= 1'b1;
		end else if (run_q && is_wr_q) begin
			wa_lo_q <= data_low_lane_i;
			wa_hi_q <= data_high_lane_i;
			wa_ml_q <= write_mask_lower || !dqs_ok_lo;
			wa_mu_q <= write_mask_upper || !dqs_ok_hi;
		end
	end

	assign mem_we    = run_q && is_wr_q;
	assign mem_wdata = {data_high_lane_i, data_low_lane_i, wa_hi_q, wa_lo_q};
	assign mem_be    = {!(write_mask_upper || !dqs_ok_hi),
		!(write_mask_lower || !dqs_ok_lo), !wa_mu_q, !wa_ml_q};

	dcai_mem #(
		.DW (32),
		.AW (MEM_AW)
	) u_mem (
		.clk     (ck),
		.we      (mem_we),
		.be      (mem_be),
		.addr    (mem_addr),
		.wdata   (mem_wdata),
		.rdata_q (mem_rdata_q)
	);

	// read pair ready one edge after the array read
	always_ff @(posedge ck or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			rd_v_q   <= 1'b0;
			drive_q  <= 1'b0;
			b_hold_q <= '0;
			dq_p_q   <= '0;
			dqs_p_q  <= 1'b0;
		end else begin
			rd_v_q   <= run_q && !is_wr_q;
			drive_q  <= rd_v_q && cke;
			b_hold_q <= mem_rdata_q[31:16];
			dq_p_q   <= (rd_v_q ? mem_rdata_q[15:0] : 16'h0000) ^ dq_n_q;
			dqs_p_q  <= rd_v_q ^ dqs_n_q;
		end
	end

	always_ff @(negedge ck or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			dq_n_q  <= '0;
			dqs_n_q <= 1'b0;
		end else begin
			dq_n_q  <= (drive_q ? b_hold_q : 16'h0000) ^ dq_p_q;
			dqs_n_q <= dqs_p_q;
		end
	end

	assign dq_out  = dq_p_q ^ dq_n_q;
	assign dqs_out = dqs_p_q ^ dqs_n_q;
	assign data_low_lane_o       = dq_out[7:0];
	assign data_high_lane_o      = dq_out[15:8];
	assign data_low_lane_oe_n    = !drive_q;
	assign data_high_lane_oe_n   = !drive_q;
	assign strobe_low_lane_o     = dqs_out;
	assign strobe_low_lane_n_o   = !dqs_out;
	assign strobe_low_lane_oe_n  = !drive_q;
	assign strobe_high_lane_o    = dqs_out;
	assign strobe_high_lane_n_o  = !dqs_out;
	assign strobe_high_lane_oe_n = !drive_q;

	assign st_w[dcai_pkg::ST_SR]   = sr_q;
	assign st_w[dcai_pkg::ST_PD]   = pwr_q != dcai_pkg::pwr_run;
	assign st_w[dcai_pkg::ST_TERM] = term_q;
	assign st_w[dcai_pkg::ST_OPEN] = |open_q;
	assign st_w[dcai_pkg::ST_BUSY] = busy_q;

	// status crossing, change taken when stages two and three agree
	for (genvar i = 0; i < dcai_pkg::ST_W; i++) begin : g_sync
		logic s1_q;
		logic s2_q;
		logic s3_q;
		always_ff @(posedge core_clk or negedge core_rst_n_q) begin
			if (!core_rst_n_q) begin
				s1_q    <= 1'b0;
				s2_q    <= 1'b0;
				s3_q    <= 1'b0;
				st_q[i] <= 1'b0;
			end else begin
				s1_q <= st_w[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q) begin
					st_q[i] <= s3_q;
				end
			end
		end
	end

	assign core_self_refresh = st_q[dcai_pkg::ST_SR];
	assign core_power_down   = st_q[dcai_pkg::ST_PD];
	assign core_term_active  = st_q[dcai_pkg::ST_TERM];
	assign core_bank_open    = st_q[dcai_pkg::ST_OPEN];
	assign core_burst_busy   = st_q[dcai_pkg::ST_BUSY];

	default clocking cb @(posedge ck);
	endclocking
	default disable iff (!link_rst_n_q);

	property p_desel;
		(cke && cke_q && cs_n && !run_q) |=> $stable(open_q);
	endproperty
	a_desel: assert property (p_desel) else $error("deselect changed banks");

	property p_act;
		act_w |=> open_q[$past(bank_select)]
			&& row_q[$past(bank_select)] == $past(addr[ROW_KEEP-1:0]);
	endproperty
	a_act: assert property (p_act) else $error("activate not taken");

	property p_pre_all;
		(pre_w && addr[dcai_pkg::AP_BIT]) |=> open_q == '0;
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("banks still open");

	property p_mrs;
		mrs_w |=> mr_q[$past(bank_select[1:0])] == $past(addr);
	endproperty
	a_mrs: assert property (p_mrs) else $error("mode write lost");

	property p_pd_act;
		(pwr_q == dcai_pkg::pwr_run && cke_q && !cke && !sr_q
			&& cmd_w != dcai_pkg::CMD_REF && |open_q)
			|=> pwr_q == dcai_pkg::pwr_pd_act;
	endproperty
	a_pd_act: assert property (p_pd_act) else $error("no active power-down");

	property p_sr_exit;
		sr_q |-> !cke;
	endproperty
	a_sr_exit: assert property (p_sr_exit) else $error("self refresh held");

	property p_sr_quiet;
		(sr_q && $past(sr_q)) |-> $stable(open_q) && !term_q && !busy_q;
	endproperty
	a_sr_quiet: assert property (p_sr_quiet) else $error("busy in self refresh");

	property p_term;
		$rose(term_q) |-> $past(termination_ctrl) && $past(rtt_on);
	endproperty
	a_term: assert property (p_term) else $error("termination unexpected");

	property p_chop;
		start_w |=> chop_q == $past(chop_w) && lat_q != '0;
	endproperty
	a_chop: assert property (p_chop) else $error("burst length wrong");

	property p_mask;
		(mem_we && write_mask_lower) |-> !mem_be[2];
	endproperty
	a_mask: assert property (p_mask) else $error("masked beat written");

	property p_ap;
		ap_fire |=> !open_q[$past(bank_q)];
	endproperty
	a_ap: assert property (p_ap) else $error("auto precharge missed");
endmodule

// *** sim/dcai_ctrl_model.sv ***
// dcai_ctrl_model: controller side, drives commands and write bursts.
// assumes the bench makes ck and calls the tasks one at a time.
`timescale 1ns/1ps
module dcai_ctrl_model #(
	parameter int WR_LAT = 5
) (
	input  wire logic        ck,
	output      logic        mem_reset_n,
	output      logic        cke,
	output      logic        cs_n,
	output      logic        ras_n,
	output      logic        cas_n,
	output      logic        we_n,
	output      logic [2:0]  bank_select,
	output      logic [15:0] addr,
	output      logic        termination_ctrl,
	output      logic        write_mask_lower,
	output      logic        write_mask_upper,
	output      logic [7:0]  wd_lo,
	output      logic [7:0]  wd_hi,
	output      logic        stb,
	output      logic        stb_n
);
	initial begin
		mem_reset_n = 1'b0;
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = 4'hF;
		bank_select = 3'h0;
		addr = 16'h0000;
		termination_ctrl = 1'b0;
		{write_mask_upper, write_mask_lower} = 2'h0;
		{wd_hi, wd_lo} = 16'h0000;
		{stb, stb_n} = 2'h0;
	end
	task automatic pins(input logic k, input logic t, input logic r);
		@(posedge ck);
		cke <= k;
		termination_ctrl <= t;
		mem_reset_n <= r;
	endtask
	// gate raised while the clock stands still
	task automatic wake();
		cke <= 1'b1;
	endtask
	task automatic cmd(input logic k, input logic [3:0] c,
		input logic [2:0] b, input logic [15:0] a);
		@(posedge ck);
		cke <= k;
		{cs_n, ras_n, cas_n, we_n} <= c;
		bank_select <= b;
		addr <= a;
		@(posedge ck);
		{cs_n, ras_n, cas_n, we_n} <= 4'hF;
		addr <= ~a;
	endtask
	task automatic wr(input logic [15:0] d [8], input logic [1:0] m [8]);
		repeat (WR_LAT) @(posedge ck);
		for (int i = 0; i < 8; i++) begin
			{wd_hi, wd_lo} <= d[i];
			{write_mask_upper, write_mask_lower} <= m[i];
			stb <= ~i[0];
			stb_n <= i[0];
			if (i[0]) @(posedge ck);
			else @(negedge ck);
		end
		// released lines show no stale beat
		{wd_hi, wd_lo} <= ~d[7];
		{write_mask_upper, write_mask_lower} <= ~m[7];
		{stb, stb_n} <= 2'h0;
	endtask
endmodule

// *** sim/dcai_device_tb.sv ***
// dcai_device_tb: controller model, read beat scoreboard, status checks.
// assumes latencies of five and the package command codes.
`timescale 1ns/1ps
module dcai_device_tb;
	localparam int LAT = 5;
	logic        core_clk, resetn, ck, ck_run, lo_oe_n;
	logic        mem_reset_n, cke, cs_n, ras_n, cas_n, we_n;
	logic        termination_ctrl, write_mask_lower, write_mask_upper;
	logic        stb, stb_n, s_lo, s_lo_n, s_hi, term_enable;
	logic        core_self_refresh, core_power_down, core_bank_open;
	logic        hi_oe_n, s_lo_oe_n, s_hi_oe_n, s_hi_n;
	logic        core_term_active, core_burst_busy;
	logic [2:0]  bank_select;
	logic [15:0] addr, rnd;
	logic [7:0]  wd_lo, wd_hi, rd_lo, rd_hi;
	logic [15:0] d0 [8];
	logic [15:0] d1 [8];
	logic [15:0] e [8];
	logic [1:0]  m0 [8];
	logic [1:0]  m1 [8];
	logic [15:0] exp_q [$];
	int          fail_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	dcai_ctrl_model #(.WR_LAT(LAT)) u_ctl (
		.ck, .mem_reset_n, .cke, .cs_n, .ras_n, .cas_n, .we_n,
		.bank_select, .addr, .termination_ctrl, .write_mask_lower,
		.write_mask_upper, .wd_lo, .wd_hi, .stb, .stb_n
	);
	dcai_device #(.RD_LAT(LAT), .WR_LAT(LAT)) DUT (
		.core_clk, .resetn, .ck, .mem_reset_n, .cke, .cs_n, .ras_n,
		.cas_n, .we_n, .bank_select, .addr, .termination_ctrl,
		.write_mask_lower, .write_mask_upper,
		.data_low_lane_i(wd_lo), .data_low_lane_o(rd_lo),
		.data_low_lane_oe_n(lo_oe_n), .data_high_lane_i(wd_hi),
		.data_high_lane_o(rd_hi), .data_high_lane_oe_n(hi_oe_n),
		.strobe_low_lane_i(stb), .strobe_low_lane_n_i(stb_n),
		.strobe_low_lane_o(s_lo), .strobe_low_lane_n_o(s_lo_n),
		.strobe_low_lane_oe_n(s_lo_oe_n), .strobe_high_lane_i(stb),
		.strobe_high_lane_n_i(stb_n), .strobe_high_lane_o(s_hi),
		.strobe_high_lane_n_o(s_hi_n),
		.strobe_high_lane_oe_n(s_hi_oe_n),
		.term_enable, .core_self_refresh, .core_power_down,
		.core_term_active, .core_bank_open, .core_burst_busy
	);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		ck = 1'b0;
		ck_run = 1'b1;
		#3.7;
		forever #15 ck = ck_run ? ~ck : 1'b0;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk_bit(input string nm, input logic s, input logic x);
		samples_checked++;
		if (s !== x) begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", nm, x, s);
		end
	endtask
	task automatic chk_beat(input logic [18:0] x, input logic [18:0] s);
		samples_checked++;
		if (s !== x) begin
			fail_count++;
			$display("ERROR read beat expected %h seen %h", x, s);
		end
	endtask
	task automatic final_report();
		if (fail_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge ck);
	endtask
	task automatic push(input logic [15:0] d [8], input int n);
		for (int i = 0; i < n; i++)
			exp_q.push_back(d[i]);
	endtask

	// oldest note against each driven beat, mid half cycle
	always @(ck) begin
		logic p;
		p = ck;
		#7;
		chk_bit("high lane oe", hi_oe_n, lo_oe_n);
		chk_bit("strobe oe", s_lo_oe_n && s_hi_oe_n, lo_oe_n);
		if (lo_oe_n === 1'b0) begin
			chk_bit("high strobe n", s_hi_n, ~s_hi);
			if (exp_q.size() == 0)
				chk_bit("beat unexpected", 1'b1, 1'b0);
			else
				chk_beat({p, ~p, p, exp_q.pop_front()},
					{s_lo, s_lo_n, s_hi, rd_hi, rd_lo});
		end
	end

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			final_report();
		end
	end

	initial begin
		resetn = 1'b0;
		rnd = 16'h0054;
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			d0[i] = rnd;
			rnd = lfsr(rnd);
			d1[i] = rnd;
			m0[i] = 2'h0;
			m1[i] = 2'(i);
			e[i][15:8] = m1[i][1] ? d0[i][15:8] : d1[i][15:8];
			e[i][7:0] = m1[i][0] ? d0[i][7:0] : d1[i][7:0];
		end
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		u_ctl.pins(1'b1, 1'b0, 1'b1);
		w(4);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_MRS, 3'h0, 16'h0001);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_ACT, 3'h3, 16'h0001);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_ACT, 3'h5, 16'h0001);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_WR, 3'h3, 16'h1000);
		u_ctl.wr(d0, m0);
		w(6);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_WR, 3'h3, 16'h1000);
		u_ctl.wr(d1, m1);
		w(6);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_WR, 3'h5, 16'h1000);
		u_ctl.wr(d1, m0);
		w(6);
		push(e, 8);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_RD, 3'h3, 16'h1000);
		w(3);
		chk_bit("burst busy", core_burst_busy, 1'b1);
		w(11);
		chk_bit("burst busy", core_burst_busy, 1'b0);
		u_ctl.cmd(1'b1, 4'hD, 3'h3, 16'h1000);
		w(14);
		push(e, 4);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_RD, 3'h3, 16'h0000);
		w(14);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_PRE, 3'h3, 16'h0000);
		w(12);
		chk_bit("bank open", core_bank_open, 1'b1);
		push(d1, 4);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_RD, 3'h5, 16'h0400);
		w(20);
		chk_bit("bank open", core_bank_open, 1'b0);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_ACT, 3'h1, 16'h0002);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_PRE, 3'h6, 16'h0400);
		w(12);
		chk_bit("bank open", core_bank_open, 1'b0);
		u_ctl.pins(1'b1, 1'b1, 1'b1);
		w(3);
		chk_bit("term", term_enable, 1'b0);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_MRS, 3'h1, 16'h0004);
		w(3);
		chk_bit("term", term_enable, 1'b1);
		chk_bit("core term", core_term_active, 1'b1);
		u_ctl.pins(1'b1, 1'b1, 1'b0);
		w(2);
		chk_bit("term", term_enable, 1'b0);
		chk_bit("core term", core_term_active, 1'b0);
		u_ctl.pins(1'b1, 1'b1, 1'b1);
		w(6);
		chk_bit("term", term_enable, 1'b0);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_ACT, 3'h2, 16'h0001);
		u_ctl.cmd(1'b0, dcai_pkg::CMD_NOP, 3'h0, 16'h0000);
		u_ctl.cmd(1'b0, dcai_pkg::CMD_RD, 3'h2, 16'h1000);
		w(14);
		chk_bit("power down", core_power_down, 1'b1);
		u_ctl.pins(1'b1, 1'b1, 1'b1);
		w(12);
		chk_bit("power down", core_power_down, 1'b0);
		u_ctl.cmd(1'b1, dcai_pkg::CMD_PRE, 3'h0, 16'h0400);
		u_ctl.cmd(1'b0, dcai_pkg::CMD_REF, 3'h0, 16'h0000);
		w(12);
		chk_bit("self refresh", core_self_refresh, 1'b1);
		ck_run = 1'b0;
		#100;
		u_ctl.wake();
		#200;
		chk_bit("self refresh", core_self_refresh, 1'b0);
		ck_run = 1'b1;
		w(4);
		chk_bit("notes left", exp_q.size() == 0, 1'b1);
		final_report();
	end
endmodule
